// ### verilog/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// sector boundaries at the top of the address space
`define FSP_ADDR_TOP 16'hffff
`define FSP_SEC0_LO 16'hf000
`define FSP_SEC1_LO 16'he000
`define FSP_SEC1_HI 16'hefff
`define FSP_SEC2_HI 16'hdfff
`define FSP_SPACE_BYTES 17'h10000
// flash sizes that change the sector count
`define FSP_SIZE_4K 32'd4096
`define FSP_SIZE_8K 32'd8192
// erased byte value
`define FSP_ERASED 8'hff
// option byte field
`define FSP_OPT_PROT_BIT 0
// protection state after reset
`define FSP_PROT_RST 1'b0

`endif

// ### verilog/fsp_pkg.sv
package fsp_pkg;

   typedef enum logic [1:0] {
      FSP_MODE_TOOL,
      FSP_MODE_IN_CIRCUIT,
      FSP_MODE_IN_APP
   } fsp_mode_t;

   typedef enum logic [2:0] {
      FSP_OP_READ,
      FSP_OP_PROG,
      FSP_OP_ERASE_SEC,
      FSP_OP_ERASE_ALL,
      FSP_OP_OPT_WRITE
   } fsp_op_t;

   typedef struct packed {
      logic valid;
      logic external;
      fsp_op_t op;
      logic [15:0] addr;
      logic [7:0] data;
   } fsp_cmd_t;

   typedef struct packed {
      logic done;
      logic refused;
      logic rvalid;
      logic [7:0] rdata;
   } fsp_rsp_t;

endpackage : fsp_pkg

// ### verilog/fsp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] ff1_r, ff2_r, ff3_r, level_r;
   logic [W-1:0] level_nxt;

   // level moves only when second and third stage agree
   always_comb
   begin
      level_nxt = level_r;
      for (int i = 0; i < W; i++)
      begin
         if (ff2_r[i] == ff3_r[i])
         begin
            level_nxt[i] = ff3_r[i];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ff1_r <= '0;
         ff2_r <= '0;
         ff3_r <= '0;
         level_r <= '0;
      end
      else
      begin
         ff1_r <= pin_i;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         level_r <= level_nxt;
      end
   end

   assign level_o = level_r;

endmodule : fsp_pin_sync

`default_nettype wire

// ### verilog/fsp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_mem #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   // array contents are not reset, only erased by command
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[addr_i] <= wdata_i;
      end
      rdata_r <= mem[addr_i];
   end

   assign rdata_o = rdata_r;

endmodule : fsp_mem

`default_nettype wire

// ### verilog/fsp_flash_ctrl.sv
// Contract
// R01 - flash erases either as one whole block or one sector at a time
// R02 - one byte per program operation, only while external programming voltage is present
// R03 - erasing or programming a sector leaves all other sectors unchanged
// R04 - tool and in-circuit modes may alter every sector and the option byte
// R05 - application mode refuses program and erase on sector 0, allows others
// R06 - sector count follows flash size: 4K one, 8K two, larger three
// R07 - sectors 0 and 1 are 4K each, sector 0 at f000h-ffffh
// R08 - while protected, external reads and all flash writes are blocked
// R09 - removing protection first erases the whole array, then clears the option
// R10 - one option byte bit turns protection on and off
// R11 - low-voltage supervisor is unavailable while protection is on
// R12 - programmer waits for completion before the next operation on a sector
`include "fsp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module fsp_flash_ctrl #(
   parameter int FLASH_BYTES = 16384,
   parameter int AW = $clog2(FLASH_BYTES)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsp_pkg::fsp_cmd_t cmd_i,
   input wire logic [1:0] mode_pin_i,
   input wire logic vpp_pin_i,
   input wire logic supervisor_request_i,
   output fsp_pkg::fsp_rsp_t rsp_o,
   output logic busy_o,
   output logic protect_o,
   output logic low_voltage_supervisor_en_o,
   output logic [1:0] sectors_o
);

   typedef enum logic [1:0] {
      FSP_ST_IDLE,
      FSP_ST_READ,
      FSP_ST_ERASE
   } fsp_state_t;

   localparam logic [16:0] BASE17 = 17'(`FSP_SPACE_BYTES - 17'(FLASH_BYTES));
   localparam logic [15:0] BASE = BASE17[15:0];
   localparam logic [1:0] SECTORS =
      (FLASH_BYTES <= `FSP_SIZE_4K) ? 2'd1 :
      (FLASH_BYTES <= `FSP_SIZE_8K) ? 2'd2 : 2'd3; // see R06

   // sector number of an address
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a >= `FSP_SEC0_LO)
      begin
         return 2'd0; // see R07
      end
      else if (a >= `FSP_SEC1_LO)
      begin
         return 2'd1;
      end
      else
      begin
         return 2'd2;
      end
   endfunction : sector_of

   // array index of an address
   function automatic logic [AW-1:0] mem_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - BASE;
      return d[AW-1:0];
   endfunction : mem_idx

   fsp_state_t st_r, st_nxt;
   fsp_pkg::fsp_rsp_t rsp_r, rsp_nxt;
   logic busy_r, busy_nxt;
   logic prot_r, prot_nxt;
   logic sup_r, sup_nxt;
   logic [15:0] ptr_r, ptr_nxt;
   logic [15:0] hi_r, hi_nxt;
   logic unprot_r, unprot_nxt;
   logic [1:0] sec_r;

   logic [1:0] mode_sync;
   logic vpp_ok;
   fsp_pkg::fsp_mode_t mode;
   logic mem_we;
   logic [AW-1:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   logic [1:0] cmd_sec;
   logic in_range;
   logic wr_ok;
   logic take;

   fsp_pin_sync #(
      .W(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({vpp_pin_i, mode_pin_i}),
      .level_o({vpp_ok, mode_sync})
   );

   assign mode = fsp_pkg::fsp_mode_t'(mode_sync);

   fsp_mem #(
      .AW(AW),
      .DW(8)
   ) u_mem (
      .clk_i(clk_i),
      .we_i(mem_we),
      .addr_i(mem_addr),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   assign take = (st_r == FSP_ST_IDLE) && cmd_i.valid; // see R12
   assign cmd_sec = sector_of(cmd_i.addr);
   assign in_range = (cmd_i.addr >= BASE); // see R06
   // writes need voltage, no protection, a present sector, no boot sector in app mode
   assign wr_ok = vpp_ok && !prot_r && in_range
      && !((mode == fsp_pkg::FSP_MODE_IN_APP) && (cmd_sec == 2'd0)); // see R05

   always_comb
   begin
      st_nxt = st_r;
      rsp_nxt = '0;
      prot_nxt = prot_r;
      ptr_nxt = ptr_r;
      hi_nxt = hi_r;
      unprot_nxt = unprot_r;
      mem_we = 1'b0;
      mem_addr = mem_idx(cmd_i.addr);
      mem_wdata = cmd_i.data;
      case (st_r)
         FSP_ST_IDLE:
         begin
            if (take)
            begin
               case (cmd_i.op)
                  fsp_pkg::FSP_OP_READ:
                  begin
                     if ((cmd_i.external && prot_r) || !in_range) // see R08
                     begin
                        rsp_nxt.refused = 1'b1;
                     end
                     else
                     begin
                        st_nxt = FSP_ST_READ;
                     end
                  end
                  fsp_pkg::FSP_OP_PROG:
                  begin
                     if (wr_ok) // see R02, R04, R08
                     begin
                        mem_we = 1'b1;
                        rsp_nxt.done = 1'b1;
                     end
                     else
                     begin
                        rsp_nxt.refused = 1'b1;
                     end
                  end
                  fsp_pkg::FSP_OP_ERASE_SEC:
                  begin
                     if (wr_ok)
                     begin
                        st_nxt = FSP_ST_ERASE; // see R01
                        unprot_nxt = 1'b0;
                        case (cmd_sec) // see R03, R07
                           2'd0:
                           begin
                              ptr_nxt = `FSP_SEC0_LO;
                              hi_nxt = `FSP_ADDR_TOP;
                           end
                           2'd1:
                           begin
                              ptr_nxt = `FSP_SEC1_LO;
                              hi_nxt = `FSP_SEC1_HI;
                           end
                           default:
                           begin
                              ptr_nxt = BASE;
                              hi_nxt = `FSP_SEC2_HI;
                           end
                        endcase
                     end
                     else
                     begin
                        rsp_nxt.refused = 1'b1;
                     end
                  end
                  fsp_pkg::FSP_OP_ERASE_ALL:
                  begin
                     if (vpp_ok && !prot_r && (mode != fsp_pkg::FSP_MODE_IN_APP)) // see R01, R05
                     begin
                        st_nxt = FSP_ST_ERASE;
                        unprot_nxt = 1'b0;
                        ptr_nxt = BASE;
                        hi_nxt = `FSP_ADDR_TOP;
                     end
                     else
                     begin
                        rsp_nxt.refused = 1'b1;
                     end
                  end
                  fsp_pkg::FSP_OP_OPT_WRITE:
                  begin
                     if (!vpp_ok || (mode == fsp_pkg::FSP_MODE_IN_APP)) // see R04
                     begin
                        rsp_nxt.refused = 1'b1;
                     end
                     else if (cmd_i.data[`FSP_OPT_PROT_BIT]) // see R10
                     begin
                        prot_nxt = 1'b1;
                        rsp_nxt.done = 1'b1;
                     end
                     else if (prot_r)
                     begin
                        st_nxt = FSP_ST_ERASE; // see R09
                        unprot_nxt = 1'b1;
                        ptr_nxt = BASE;
                        hi_nxt = `FSP_ADDR_TOP;
                     end
                     else
                     begin
                        rsp_nxt.done = 1'b1;
                     end
                  end
                  default:
                  begin
                     rsp_nxt.refused = 1'b1;
                  end
               endcase
            end
         end
         FSP_ST_READ:
         begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.done = 1'b1;
            rsp_nxt.rdata = mem_rdata;
            st_nxt = FSP_ST_IDLE;
         end
         FSP_ST_ERASE:
         begin
            mem_we = 1'b1;
            mem_addr = mem_idx(ptr_r);
            mem_wdata = `FSP_ERASED;
            ptr_nxt = ptr_r + 16'h0001;
            if (ptr_r == hi_r)
            begin
               st_nxt = FSP_ST_IDLE;
               rsp_nxt.done = 1'b1;
               if (unprot_r)
               begin
                  prot_nxt = 1'b0; // see R09
               end
            end
         end
         default:
         begin
            st_nxt = FSP_ST_IDLE;
         end
      endcase
      busy_nxt = (st_nxt != FSP_ST_IDLE);
      sup_nxt = supervisor_request_i && !prot_nxt; // see R11
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= FSP_ST_IDLE;
         rsp_r <= '0;
         busy_r <= 1'b0;
         prot_r <= `FSP_PROT_RST;
         sup_r <= 1'b0;
         ptr_r <= 16'h0000;
         hi_r <= 16'h0000;
         unprot_r <= 1'b0;
         sec_r <= 2'd0;
      end
      else
      begin
         st_r <= st_nxt;
         rsp_r <= rsp_nxt;
         busy_r <= busy_nxt;
         prot_r <= prot_nxt;
         sup_r <= sup_nxt;
         ptr_r <= ptr_nxt;
         hi_r <= hi_nxt;
         unprot_r <= unprot_nxt;
         sec_r <= SECTORS;
      end
   end

   assign rsp_o = rsp_r;
   assign busy_o = busy_r;
   assign protect_o = prot_r;
   assign low_voltage_supervisor_en_o = sup_r;
   assign sectors_o = sec_r;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_unprot_start;
      take && (cmd_i.op == fsp_pkg::FSP_OP_OPT_WRITE) && vpp_ok && prot_r
         && (mode != fsp_pkg::FSP_MODE_IN_APP) && !cmd_i.data[`FSP_OPT_PROT_BIT];
   endsequence

   sequence s_erase_end;
      (st_r == FSP_ST_ERASE) && (ptr_r == hi_r);
   endsequence

   property p_r01;
      take && (cmd_i.op == fsp_pkg::FSP_OP_ERASE_ALL) && vpp_ok && !prot_r
         && (mode != fsp_pkg::FSP_MODE_IN_APP) |=> busy_o && (ptr_r == BASE);
   endproperty
   a_r01: assert property (p_r01) else $error("whole erase did not start"); // see R01

   property p_r02;
      take && (cmd_i.op == fsp_pkg::FSP_OP_PROG) && !vpp_ok |=> rsp_o.refused && !rsp_o.done;
   endproperty
   a_r02: assert property (p_r02) else $error("program without voltage not refused"); // see R02

   property p_r03;
      (st_r == FSP_ST_ERASE) && !unprot_r && (hi_r != `FSP_ADDR_TOP || ptr_r >= `FSP_SEC0_LO)
         |-> (sector_of(ptr_r) == sector_of(hi_r));
   endproperty
   a_r03: assert property (p_r03) else $error("erase left its sector"); // see R03

   property p_r04;
      take && ((cmd_i.op == fsp_pkg::FSP_OP_PROG) || (cmd_i.op == fsp_pkg::FSP_OP_ERASE_SEC))
         && vpp_ok && !prot_r && (cmd_sec == 2'd0) && (mode != fsp_pkg::FSP_MODE_IN_APP)
         |=> !rsp_o.refused;
   endproperty
   a_r04: assert property (p_r04) else $error("boot sector write refused outside app mode"); // see R04

   property p_r05;
      take && (mode == fsp_pkg::FSP_MODE_IN_APP) && (cmd_sec == 2'd0)
         && ((cmd_i.op == fsp_pkg::FSP_OP_PROG) || (cmd_i.op == fsp_pkg::FSP_OP_ERASE_SEC))
         |-> !mem_we ##1 rsp_o.refused;
   endproperty
   a_r05: assert property (p_r05) else $error("app mode altered boot sector"); // see R05

   property p_r06;
      take && (cmd_i.op == fsp_pkg::FSP_OP_PROG) && (cmd_i.addr < BASE) |=> rsp_o.refused;
   endproperty
   a_r06: assert property (p_r06) else $error("absent sector accepted"); // see R06

   property p_r08;
      take && prot_r && ((cmd_i.op == fsp_pkg::FSP_OP_PROG) || (cmd_i.external
         && (cmd_i.op == fsp_pkg::FSP_OP_READ))) |-> !mem_we ##1 (rsp_o.refused && !rsp_o.rvalid);
   endproperty
   a_r08: assert property (p_r08) else $error("protected access not blocked"); // see R08

   sequence s_unprot_run;
      (st_r == FSP_ST_ERASE) && unprot_r;
   endsequence

   property p_r09;
      s_unprot_start |=> s_unprot_run ##0 (protect_o && busy_o);
   endproperty
   a_r09: assert property (p_r09) else $error("protection dropped before erase"); // see R09

   property p_r09b;
      $fell(protect_o) |-> ($past(st_r) == FSP_ST_ERASE) && rsp_o.done;
   endproperty
   a_r09b: assert property (p_r09b) else $error("protection cleared without erase"); // see R09

   property p_r09c;
      s_unprot_run |-> protect_o;
   endproperty
   a_r09c: assert property (p_r09c) else $error("protection dropped during erase"); // see R09

   property p_r09d;
      s_erase_end ##0 unprot_r |=> !protect_o && rsp_o.done;
   endproperty
   a_r09d: assert property (p_r09d) else $error("protection kept after erase"); // see R09

   property p_r10;
      take && (cmd_i.op == fsp_pkg::FSP_OP_OPT_WRITE) && vpp_ok
         && (mode != fsp_pkg::FSP_MODE_IN_APP) && cmd_i.data[`FSP_OPT_PROT_BIT] |=> protect_o;
   endproperty
   a_r10: assert property (p_r10) else $error("option bit did not protect"); // see R10

   property p_r11;
      protect_o |-> !low_voltage_supervisor_en_o;
   endproperty
   a_r11: assert property (p_r11) else $error("supervisor on while protected"); // see R11

endmodule : fsp_flash_ctrl

`default_nettype wire

// ### testbench/fsp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_prog_model (
   input wire logic clk_i,
   input wire fsp_pkg::fsp_rsp_t rsp_i,
   output fsp_pkg::fsp_cmd_t cmd_o
);

   initial
   begin
      cmd_o = '0;
   end

   // one request, driven after the first edge and taken on the second, then wait for its answer
   task automatic xfer(input fsp_pkg::fsp_op_t op, input logic [15:0] addr,
      input logic [7:0] data, input logic ext, output logic refused,
      output logic [7:0] rdata);
      fsp_pkg::fsp_cmd_t req;
      int n;
      req = '{valid: 1'b1, external: ext, op: op, addr: addr, data: data};
      refused = 1'bx;
      rdata = 8'hxx;
      @(posedge clk_i);
      cmd_o <= req;
      @(posedge clk_i);
      // released fields toggle so stale values never look valid
      req = fsp_pkg::fsp_cmd_t'(~req);
      req.valid = 1'b0;
      cmd_o <= req;
      for (n = 0; n < 20000; n++)
      begin
         @(posedge clk_i);
         if (rsp_i.done || rsp_i.refused)
         begin
            refused = rsp_i.refused;
            rdata = rsp_i.rdata;
            break;
         end
      end
   endtask : xfer

endmodule : fsp_prog_model

`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;

   typedef struct packed {
      logic [1:0] mode;
      logic vpp;
      logic ext;
      fsp_pkg::fsp_op_t op;
      logic [15:0] addr;
      logic [7:0] data;
      logic refused;
   } fsp_row_t;

   localparam fsp_pkg::fsp_op_t RD = fsp_pkg::FSP_OP_READ;
   localparam fsp_pkg::fsp_op_t PG = fsp_pkg::FSP_OP_PROG;
   localparam fsp_pkg::fsp_op_t ES = fsp_pkg::FSP_OP_ERASE_SEC;
   localparam fsp_pkg::fsp_op_t EA = fsp_pkg::FSP_OP_ERASE_ALL;
   localparam fsp_pkg::fsp_op_t OW = fsp_pkg::FSP_OP_OPT_WRITE;
   localparam int NROW = 22;

   logic clk = 1'b0;
   logic rst;
   logic [1:0] mode_pin;
   logic vpp_pin;
   logic sup_req;
   fsp_pkg::fsp_cmd_t cmd;
   fsp_pkg::fsp_rsp_t rsp;
   logic busy;
   logic prot;
   logic sup_en;
   logic [1:0] sectors;
   int err_total = 0;
   int n_tests = 0;
   logic rf;
   logic [7:0] rd;
   fsp_row_t rows [NROW];

   fsp_flash_ctrl #(.FLASH_BYTES(16384)) dut (.clk_i(clk), .rst_i(rst), .cmd_i(cmd),
      .mode_pin_i(mode_pin), .vpp_pin_i(vpp_pin), .supervisor_request_i(sup_req), .rsp_o(rsp),
      .busy_o(busy), .protect_o(prot), .low_voltage_supervisor_en_o(sup_en),
      .sectors_o(sectors));

   fsp_prog_model prog (.clk_i(clk), .rsp_i(rsp), .cmd_o(cmd));

   always #2 clk = ~clk;

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic conclude();
      $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic pins(input logic [1:0] m, input logic v);
      @(posedge clk);
      mode_pin <= m;
      vpp_pin <= v;
      repeat (6) @(posedge clk);
   endtask : pins

   task automatic run(input fsp_pkg::fsp_op_t op, input logic [15:0] a, input logic [7:0] d,
      input logic ext, input logic exp_ref);
      prog.xfer(op, a, d, ext, rf, rd);
      chk1(rf, exp_ref);
   endtask : run

   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      conclude();
   end

   initial
   begin
      // mode, vpp, external, op, addr, data or expected read, refused
      rows = '{
         '{2'h0, 1'b1, 1'b1, PG, 16'hf000, 8'ha5, 1'b0}, '{2'h0, 1'b1, 1'b1, RD, 16'hf000, 8'ha5, 1'b0},
         '{2'h0, 1'b1, 1'b1, PG, 16'hefff, 8'h11, 1'b0}, '{2'h0, 1'b1, 1'b1, PG, 16'hdfff, 8'h77, 1'b0},
         '{2'h0, 1'b1, 1'b1, PG, 16'hc002, 8'h5a, 1'b0}, '{2'h0, 1'b1, 1'b1, PG, 16'hbfff, 8'h00, 1'b1},
         '{2'h0, 1'b1, 1'b1, RD, 16'hbfff, 8'h00, 1'b1}, '{2'h0, 1'b0, 1'b1, PG, 16'hf001, 8'h00, 1'b1},
         '{2'h0, 1'b0, 1'b1, OW, 16'h0000, 8'h01, 1'b1}, '{2'h2, 1'b1, 1'b0, PG, 16'hf003, 8'h00, 1'b1},
         '{2'h2, 1'b1, 1'b0, ES, 16'hf800, 8'h00, 1'b1}, '{2'h2, 1'b1, 1'b0, EA, 16'h0000, 8'h00, 1'b1},
         '{2'h2, 1'b1, 1'b0, OW, 16'h0000, 8'h01, 1'b1}, '{2'h2, 1'b1, 1'b0, PG, 16'he003, 8'h66, 1'b0},
         '{2'h2, 1'b1, 1'b0, ES, 16'he123, 8'h00, 1'b0}, '{2'h2, 1'b1, 1'b0, RD, 16'hefff, 8'hff, 1'b0},
         '{2'h2, 1'b1, 1'b0, RD, 16'he003, 8'hff, 1'b0}, '{2'h2, 1'b1, 1'b0, RD, 16'hdfff, 8'h77, 1'b0},
         '{2'h1, 1'b1, 1'b1, RD, 16'hf000, 8'ha5, 1'b0}, '{2'h1, 1'b1, 1'b1, ES, 16'hffff, 8'h00, 1'b0},
         '{2'h1, 1'b1, 1'b1, RD, 16'hf000, 8'hff, 1'b0}, '{2'h1, 1'b1, 1'b1, RD, 16'hc002, 8'h5a, 1'b0}};
      rst = 1'b1;
      mode_pin = 2'h0;
      vpp_pin = 1'b1;
      sup_req = 1'b0;
      repeat (2) @(posedge clk);
      chk8({6'h00, sectors}, 8'h00);
      chk1(busy, 1'b0);
      chk1(prot, 1'b0);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk8({6'h00, sectors}, 8'h03);
      chk1(sup_en, 1'b0);
      foreach (rows[i])
      begin
         if (i == 0 || rows[i].mode !== rows[i-1].mode || rows[i].vpp !== rows[i-1].vpp)
         begin
            pins(rows[i].mode, rows[i].vpp);
         end
         run(rows[i].op, rows[i].addr, rows[i].data, rows[i].ext, rows[i].refused);
         if (rows[i].op == RD && !rows[i].refused)
         begin
            chk8(rd, rows[i].data);
         end
      end
      // protection on, then removed through the option bit
      pins(2'h0, 1'b1);
      sup_req <= 1'b1;
      repeat (6) @(posedge clk);
      chk1(sup_en, 1'b1);
      run(OW, 16'h0000, 8'h01, 1'b1, 1'b0);
      @(posedge clk);
      chk1(prot, 1'b1);
      chk1(sup_en, 1'b0);
      run(RD, 16'hf000, 8'h00, 1'b1, 1'b1);
      run(RD, 16'hc002, 8'h00, 1'b0, 1'b0);
      chk8(rd, 8'h5a);
      run(PG, 16'hc003, 8'h12, 1'b1, 1'b1);
      run(ES, 16'hc000, 8'h00, 1'b1, 1'b1);
      run(OW, 16'h0000, 8'h00, 1'b1, 1'b0);
      @(posedge clk);
      chk1(prot, 1'b0);
      chk1(sup_en, 1'b1);
      run(RD, 16'hc002, 8'h00, 1'b1, 1'b0);
      chk8(rd, 8'hff);
      run(RD, 16'hf000, 8'h00, 1'b1, 1'b0);
      chk8(rd, 8'hff);
      run(PG, 16'hc002, 8'h3c, 1'b1, 1'b0);
      run(EA, 16'h0000, 8'h00, 1'b1, 1'b0);
      run(RD, 16'hc002, 8'h00, 1'b1, 1'b0);
      chk8(rd, 8'hff);
      conclude();
   end

endmodule : tb_top

`default_nettype wire
